// *** rtl/rpsc_idle_timer.v ***
// signal-detect synchroniser and automatic low-power idle timer
`default_nettype none
`include "rpsc_regs.vh"

module rpsc_idle_timer (
	input wire i_clock, // block clock
	input wire i_sys_rst, // async reset, high
	input wire [1:0] i_detect, // raw signal detect, lane b/a
	input wire i_enable, // esata mode selected
	output reg [1:0] o_detect, // synchronised detect
	output reg o_low_power // idle long enough
);

// full-width count first, then cut on purpose to the counter width
localparam [31:0] IDLE_FULL = `RPSC_IDLE_CYC;
localparam [11:0] IDLE_CYC = IDLE_FULL[11:0];

reg [1:0] detect_meta;
reg [11:0] count;

////////////////////////////////////////////////////////////////
// detect stays live in low power, so it is never gated
always @(posedge i_clock or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		detect_meta <= 2'h0;
		o_detect <= 2'h0;
	end else begin
		detect_meta <= i_detect;
		o_detect <= detect_meta;
	end
end

////////////////////////////////////////////////////////////////
// count idle cycles; any activity wakes at once
always @(posedge i_clock or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		count <= 12'h000;
		o_low_power <= 1'b0;
	end else if (!i_enable || (o_detect != 2'h0)) begin
		count <= 12'h000;
		o_low_power <= 1'b0;
	end else if (count == IDLE_CYC - 12'h001) begin
		o_low_power <= 1'b1;
	end else begin
		count <= count + 12'h001;
	end
end

endmodule
`default_nettype wire

// *** rtl/rpsc_regs.vh ***
// constants for the repeater strap and control block
`ifndef RPSC_REGS_VH
`define RPSC_REGS_VH

// register byte offsets
`define RPSC_OFS_CTRL 8'h00
`define RPSC_OFS_LANE_A 8'h04
`define RPSC_OFS_LANE_B 8'h08
`define RPSC_OFS_STRAP 8'h0C
`define RPSC_OFS_STATUS 8'h10
`define RPSC_OFS_MASK 8'h14
`define RPSC_OFS_STATE 8'h18

// reset values
`define RPSC_RST_CTRL 3'h0
`define RPSC_RST_LANE 10'h000
`define RPSC_RST_MASK 4'h0

// control register fields
`define RPSC_CTRL_LOS_SRC 1:0
`define RPSC_CTRL_SWING_OVR 2

// lane register fields
`define RPSC_LANE_EQ 3:0
`define RPSC_LANE_DEEMPH 7:4
`define RPSC_LANE_SWING 9:8

// status and mask bit positions
`define RPSC_EV_LOAD_OK 0
`define RPSC_EV_LOAD_ERR 1
`define RPSC_EV_LOS 2
`define RPSC_EV_LOW_POWER 3

// four-level strap codes
`define RPSC_LVL_LOW 2'h0
`define RPSC_LVL_20K 2'h1
`define RPSC_LVL_FLOAT 2'h2
`define RPSC_LVL_HIGH 2'h3

// configuration source codes
`define RPSC_SRC_PIN 2'h0
`define RPSC_SRC_EEPROM 2'h1
`define RPSC_SRC_SLAVE 2'h2

// swing codes
`define RPSC_SWING_700MV 2'h0
`define RPSC_SWING_1V0 2'h1
`define RPSC_SWING_1V2 2'h2
`define RPSC_SWING_MAX 2'h3

// operating mode codes
`define RPSC_MODE_SAS 2'h0
`define RPSC_MODE_ESATA 2'h1
`define RPSC_MODE_SLOW_OOB 2'h2
`define RPSC_MODE_CONT_TALK 2'h3

// loss-of-signal source select
`define RPSC_LOS_LANE_A 2'h0
`define RPSC_LOS_LANE_B 2'h1
`define RPSC_LOS_EITHER 2'h2

// slave address forming
`define RPSC_ADDR_BASE 8'hA0
`define RPSC_ADDR_FIXED 8'hB0

// timing
`define RPSC_CLK_MHZ 20
`define RPSC_IDLE_NS 100000
`define RPSC_IDLE_CYC ((`RPSC_IDLE_NS * `RPSC_CLK_MHZ + 999) / 1000)
`define RPSC_SETTLE_CYC 5'h10

`endif

// *** rtl/rpsc_strap_sample.v ***
// synchroniser and one-time capture of all four-level strap codes
`default_nettype none
`include "rpsc_regs.vh"

module rpsc_strap_sample (
	input wire i_clock, // block clock
	input wire i_sys_rst, // async reset, high
	input wire [19:0] i_raw, // raw level codes, two bits a pin
	output reg [19:0] o_code, // held codes
	output reg o_valid // codes captured
);

reg [19:0] sync_a;
reg [19:0] sync_b;
reg [4:0] settle;

////////////////////////////////////////////////////////////////
// two-flop synchroniser on the pad comparators
always @(posedge i_clock or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		sync_a <= 20'h00000;
		sync_b <= 20'h00000;
	end else begin
		sync_a <= i_raw;
		sync_b <= sync_a;
	end
end

////////////////////////////////////////////////////////////////
// wait for pads to settle, capture once, then hold
always @(posedge i_clock or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		settle <= 5'h00;
		o_code <= 20'h00000;
		o_valid <= 1'b0;
	end else if (!o_valid) begin
		if (settle == `RPSC_SETTLE_CYC) begin
			o_code <= sync_b;
			o_valid <= 1'b1;
		end else begin
			settle <= settle + 5'h01;
		end
	end
end

endmodule
`default_nettype wire

// *** rtl/rpsc_top.v ***
// strap decoding, settings, eeprom load status and loss flag of the repeater
// Contract
// - management enable strap picks configuration source
// - four address straps form slave address
// - swing strap high forces address B0h
// - load starts on falling load request
// - load status low only after clean load
// - eq straps only in pin mode
// - de-emphasis straps only in pin mode
// - output disable turns off lane b only
// - swing strap decodes to four swing levels
// - pin mode limits lane a to 700mV
// - mode strap decodes four operating modes
// - esata mode sleeps after 100us idle
// - open-drain loss flag, lane a default
// - threshold strap decodes four threshold pairs
//
// Strobed register access and the address map are this design's own decisions.
`default_nettype none
`include "rpsc_regs.vh"

module rpsc_top (
	input wire i_clock, // 20 MHz clock
	input wire i_sys_rst, // async reset, high
	input wire [1:0] i_mgmt_bus_enable, // level code of enable strap
	input wire [3:0] i_lane_a_eq_strap, // two pin codes, also addr 0/1
	input wire [3:0] i_lane_b_eq_strap, // two pin codes, also addr 2/3
	input wire [3:0] i_deemph_strap, // two pin codes
	input wire [1:0] i_swing_select, // level code
	input wire [1:0] i_mode_strap, // level code
	input wire [1:0] i_detect_threshold_strap, // level code
	input wire i_eeprom_load_req_n, // load request, low active
	input wire i_output_disable, // output disable pin
	input wire [1:0] i_signal_detect, // analog detect, lane b/a
	input wire i_load_done, // loader finished, same clock
	input wire i_load_error, // loader failed, same clock
	input wire [7:0] i_addr, // register byte address
	input wire [31:0] i_wr_data, // write data
	input wire i_wr, // write strobe
	input wire i_rd, // read strobe
	output reg [31:0] o_rd_data, // read data, cycle after strobe
	output reg o_irq, // interrupt level
	output reg [1:0] o_cfg_source, // configuration source
	output reg [7:0] o_slave_addr, // management slave address
	output reg o_load_start, // one-cycle pulse to loader
	output reg o_eeprom_load_status_n, // load status pin
	output reg [3:0] o_lane_a_eq, // lane a equalization
	output reg [3:0] o_lane_b_eq, // lane b equalization
	output reg [3:0] o_lane_a_deemph, // lane a de-emphasis
	output reg [3:0] o_lane_b_deemph, // lane b de-emphasis
	output reg [1:0] o_lane_a_swing, // lane a swing code
	output reg [1:0] o_lane_b_swing, // lane b swing code
	output reg o_lane_a_output_en, // lane a driver on
	output reg o_lane_b_output_en, // lane b driver on
	output reg [1:0] o_op_mode, // operating mode code
	output reg [1:0] o_detect_threshold, // threshold pair code
	output reg o_low_power, // automatic low power
	output reg o_signal_loss_flag, // loss flag pin output value
	output reg o_signal_loss_flag_oe_n // low while pin pulled down
);

localparam [1:0] LD_IDLE = 2'h0;
localparam [1:0] LD_BUSY = 2'h1;
localparam [1:0] LD_OK = 2'h2;
localparam [1:0] LD_FAIL = 2'h3;

wire [19:0] strap_code;
wire straps_valid;
wire [1:0] detect;
wire idle_low_power;

reg req_meta;
reg req_sync;
reg req_prev;
reg dis_meta;
reg dis_sync;
reg [1:0] load_state;
reg [1:0] next_load_state;
reg [2:0] ctrl;
reg [9:0] lane_a_reg;
reg [9:0] lane_b_reg;
reg [3:0] status;
reg [3:0] mask;
reg los_prev;
reg lp_prev;
reg [1:0] next_src;
reg [7:0] next_addr;
reg next_los;
reg [3:0] events;
reg [31:0] next_rd_data;

// address bit from a strap that must be tied low or high
function pin_bit;
	input [1:0] lvl;
	begin
		pin_bit = (lvl == `RPSC_LVL_HIGH);
	end
endfunction

// swing level from the four-level swing strap
function [1:0] swing_code;
	input [1:0] lvl;
	begin
		case (lvl)
			`RPSC_LVL_LOW: swing_code = `RPSC_SWING_700MV;
			`RPSC_LVL_20K: swing_code = `RPSC_SWING_1V2;
			`RPSC_LVL_FLOAT: swing_code = `RPSC_SWING_1V0;
			default: swing_code = `RPSC_SWING_MAX;
		endcase
	end
endfunction

// strap code field names
wire [1:0] s_mgmt = strap_code[1:0];
wire [3:0] s_eq_a = strap_code[5:2];
wire [3:0] s_eq_b = strap_code[9:6];
wire [3:0] s_dem = strap_code[13:10];
wire [1:0] s_swing = strap_code[15:14];
wire [1:0] s_mode = strap_code[17:16];
wire [1:0] s_thresh = strap_code[19:18];

////////////////////////////////////////////////////////////////
// strap capture and idle timer
rpsc_strap_sample u_sample (
	.i_clock(i_clock),
	.i_sys_rst(i_sys_rst),
	.i_raw({i_detect_threshold_strap, i_mode_strap, i_swing_select, i_deemph_strap,
		i_lane_b_eq_strap, i_lane_a_eq_strap, i_mgmt_bus_enable}),
	.o_code(strap_code),
	.o_valid(straps_valid)
);

rpsc_idle_timer u_idle (
	.i_clock(i_clock),
	.i_sys_rst(i_sys_rst),
	.i_detect(i_signal_detect),
	.i_enable(straps_valid && (o_op_mode == `RPSC_MODE_ESATA)),
	.o_detect(detect),
	.o_low_power(idle_low_power)
);

////////////////////////////////////////////////////////////////
// synchronisers for the plain control pins
always @(posedge i_clock or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		req_meta <= 1'b1;
		req_sync <= 1'b1;
		req_prev <= 1'b1;
		dis_meta <= 1'b0;
		dis_sync <= 1'b0;
	end else begin
		req_meta <= i_eeprom_load_req_n;
		req_sync <= req_meta;
		req_prev <= req_sync;
		dis_meta <= i_output_disable;
		dis_sync <= dis_meta;
	end
end

////////////////////////////////////////////////////////////////
// source, address and loss decode
always @* begin
	case (s_mgmt)
		`RPSC_LVL_HIGH: next_src = `RPSC_SRC_SLAVE;
		`RPSC_LVL_FLOAT: next_src = `RPSC_SRC_EEPROM;
		default: next_src = `RPSC_SRC_PIN;
	endcase
	if (s_swing == `RPSC_LVL_HIGH)
		next_addr = `RPSC_ADDR_FIXED;
	else
		next_addr = `RPSC_ADDR_BASE | {3'h0, pin_bit(s_eq_b[3:2]), pin_bit(s_eq_b[1:0]),
			pin_bit(s_eq_a[3:2]), pin_bit(s_eq_a[1:0]), 1'b0};
	case (ctrl[`RPSC_CTRL_LOS_SRC])
		`RPSC_LOS_LANE_B: next_los = !detect[1];
		`RPSC_LOS_EITHER: next_los = (detect != 2'h3);
		default: next_los = !detect[0];
	endcase
end

////////////////////////////////////////////////////////////////
// eeprom load sequence
always @* begin
	next_load_state = load_state;
	case (load_state)
		LD_BUSY: begin
			if (i_load_error)
				next_load_state = LD_FAIL;
			else if (i_load_done)
				next_load_state = LD_OK;
		end
		default: begin
			if (straps_valid && (o_cfg_source == `RPSC_SRC_EEPROM) && req_prev && !req_sync)
				next_load_state = LD_BUSY;
		end
	endcase
end

always @(posedge i_clock or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		load_state <= LD_IDLE;
		o_load_start <= 1'b0;
		o_eeprom_load_status_n <= 1'b1;
	end else begin
		load_state <= next_load_state;
		o_load_start <= (next_load_state == LD_BUSY) && (load_state != LD_BUSY);
		o_eeprom_load_status_n <= (next_load_state != LD_OK);
	end
end

////////////////////////////////////////////////////////////////
// settings outputs, straps in pin mode, registers otherwise, but swing from registers only with the override bit set
always @(posedge i_clock or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		o_cfg_source <= `RPSC_SRC_PIN;
		o_slave_addr <= `RPSC_ADDR_BASE;
		o_lane_a_eq <= 4'h0;
		o_lane_b_eq <= 4'h0;
		o_lane_a_deemph <= 4'h0;
		o_lane_b_deemph <= 4'h0;
		o_lane_a_swing <= `RPSC_SWING_700MV;
		o_lane_b_swing <= `RPSC_SWING_700MV;
		o_lane_a_output_en <= 1'b0;
		o_lane_b_output_en <= 1'b0;
		o_op_mode <= `RPSC_MODE_SAS;
		o_detect_threshold <= `RPSC_LVL_FLOAT;
		o_low_power <= 1'b0;
		o_signal_loss_flag <= 1'b0;
		o_signal_loss_flag_oe_n <= 1'b1;
	end else if (straps_valid) begin
		o_cfg_source <= next_src;
		o_slave_addr <= next_addr;
		o_op_mode <= s_mode;
		o_detect_threshold <= s_thresh;
		o_lane_a_output_en <= 1'b1;
		o_lane_b_output_en <= !dis_sync;
		o_low_power <= idle_low_power;
		o_signal_loss_flag <= 1'b0;
		o_signal_loss_flag_oe_n <= next_los;
		if (next_src == `RPSC_SRC_PIN) begin
			o_lane_a_eq <= s_eq_a;
			o_lane_b_eq <= s_eq_b;
			o_lane_a_deemph <= s_dem;
			o_lane_b_deemph <= s_dem;
			o_lane_a_swing <= `RPSC_SWING_700MV;
			o_lane_b_swing <= swing_code(s_swing);
		end else begin
			o_lane_a_eq <= lane_a_reg[`RPSC_LANE_EQ];
			o_lane_b_eq <= lane_b_reg[`RPSC_LANE_EQ];
			o_lane_a_deemph <= lane_a_reg[`RPSC_LANE_DEEMPH];
			o_lane_b_deemph <= lane_b_reg[`RPSC_LANE_DEEMPH];
			if (ctrl[`RPSC_CTRL_SWING_OVR]) begin
				o_lane_a_swing <= lane_a_reg[`RPSC_LANE_SWING];
				o_lane_b_swing <= lane_b_reg[`RPSC_LANE_SWING];
			end else begin
				o_lane_a_swing <= swing_code(s_swing);
				o_lane_b_swing <= swing_code(s_swing);
			end
		end
	end
end

////////////////////////////////////////////////////////////////
// events: load ends, loss rising, low-power entry
always @* begin
	events = 4'h0;
	events[`RPSC_EV_LOAD_OK] = (load_state == LD_BUSY) && (next_load_state == LD_OK);
	events[`RPSC_EV_LOAD_ERR] = (load_state == LD_BUSY) && (next_load_state == LD_FAIL);
	events[`RPSC_EV_LOS] = o_signal_loss_flag_oe_n && !los_prev; // released pin means loss
	events[`RPSC_EV_LOW_POWER] = o_low_power && !lp_prev;
end

////////////////////////////////////////////////////////////////
// writable registers and sticky status, set beats read-clear
always @(posedge i_clock or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		ctrl <= `RPSC_RST_CTRL;
		lane_a_reg <= `RPSC_RST_LANE;
		lane_b_reg <= `RPSC_RST_LANE;
		mask <= `RPSC_RST_MASK;
		status <= 4'h0;
		los_prev <= 1'b1;
		lp_prev <= 1'b0;
		o_irq <= 1'b0;
	end else begin
		los_prev <= o_signal_loss_flag_oe_n;
		lp_prev <= o_low_power;
		if (i_wr) begin
			case (i_addr)
				`RPSC_OFS_CTRL: ctrl <= i_wr_data[2:0];
				`RPSC_OFS_LANE_A: lane_a_reg <= i_wr_data[9:0];
				`RPSC_OFS_LANE_B: lane_b_reg <= i_wr_data[9:0];
				`RPSC_OFS_MASK: mask <= i_wr_data[3:0];
				default: ;
			endcase
		end
		if (i_rd && (i_addr == `RPSC_OFS_STATUS))
			status <= events;
		else
			status <= status | events;
		o_irq <= |(((i_rd && (i_addr == `RPSC_OFS_STATUS)) ? events : (status | events)) & mask);
	end
end

////////////////////////////////////////////////////////////////
// read mux, data valid the cycle after the strobe
always @* begin
	case (i_addr)
		`RPSC_OFS_CTRL: next_rd_data = {29'h0, ctrl};
		`RPSC_OFS_LANE_A: next_rd_data = {22'h0, lane_a_reg};
		`RPSC_OFS_LANE_B: next_rd_data = {22'h0, lane_b_reg};
		`RPSC_OFS_STRAP: next_rd_data = {11'h0, straps_valid, strap_code};
		`RPSC_OFS_STATUS: next_rd_data = {28'h0, status};
		`RPSC_OFS_MASK: next_rd_data = {28'h0, mask};
		`RPSC_OFS_STATE: next_rd_data = {16'h0000, o_slave_addr, o_op_mode,
			o_signal_loss_flag_oe_n, o_low_power, !o_eeprom_load_status_n,
			(load_state == LD_BUSY), o_cfg_source};
		default: next_rd_data = 32'h00000000;
	endcase
end

always @(posedge i_clock or posedge i_sys_rst) begin
	if (i_sys_rst)
		o_rd_data <= 32'h00000000;
	else if (i_rd)
		o_rd_data <= next_rd_data;
	else
		o_rd_data <= 32'h00000000;
end

endmodule
`default_nettype wire

// *** tb/rpsc_loader_model.sv ***
// behavioural model of the external configuration loader
`default_nettype none

module rpsc_loader_model (
	input wire logic i_clock, // block clock
	input wire logic i_sys_rst, // async reset, high
	input wire logic i_start, // load start pulse
	input wire logic i_fail, // answer with an error
	input wire logic [7:0] i_lat, // answer delay, cycles
	output logic o_done, // load finished
	output logic o_error // load failed
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt;

	////////////////////////////////////////////////////////////////////////////////
	// answers each start after the chosen delay with a one-cycle pulse
	always @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt <= 8'h00;
			o_done <= 1'h0;
			o_error <= 1'h0;
		end else begin
			o_done <= 1'h0;
			o_error <= 1'h0;
			if (i_start)
				cnt <= i_lat;
			else if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
				o_done <= cnt == 8'h01 && !i_fail;
				o_error <= cnt == 8'h01 && i_fail;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/rpsc_monitor.sv ***
// concurrent checks on the ports of the repeater strap and control block
`default_nettype none
`include "rpsc_regs.vh"

module rpsc_monitor (
	input wire logic i_clock, // block clock
	input wire logic i_sys_rst, // async reset, high
	input wire logic [1:0] i_swing_select, // swing strap code
	input wire logic i_eeprom_load_req_n, // load request, low
	input wire logic i_output_disable, // lane b disable
	input wire logic [1:0] i_signal_detect, // detect, lane b/a
	input wire logic i_load_done, // loader done
	input wire logic i_load_error, // loader failed
	input wire logic o_irq, // interrupt level
	input wire logic [1:0] o_cfg_source, // config source
	input wire logic [7:0] o_slave_addr, // slave address
	input wire logic o_load_start, // load start pulse
	input wire logic o_eeprom_load_status_n, // load status
	input wire logic [1:0] o_lane_a_swing, // lane a swing
	input wire logic o_lane_a_output_en, // lane a on
	input wire logic o_lane_b_output_en, // lane b on
	input wire logic [1:0] o_op_mode, // operating mode
	input wire logic o_low_power, // low power state
	input wire logic o_signal_loss_flag // loss pin value
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	////////////////////////////////////////////////////////////////////////////////
	// settings against their straps
	pin_swing_a: assert property (
		o_cfg_source == `RPSC_SRC_PIN |-> o_lane_a_swing == `RPSC_SWING_700MV)
		else $error("lane a swing not limited");
	fixed_addr_a: assert property (
		o_cfg_source == `RPSC_SRC_SLAVE && i_swing_select == `RPSC_LVL_HIGH
		|-> o_slave_addr == `RPSC_ADDR_FIXED) else $error("fixed address missing");
	lane_a_on_a: assert property (o_lane_b_output_en |-> o_lane_a_output_en)
		else $error("lane a off while lane b on");
	lane_b_off_a: assert property (i_output_disable [*5] |-> !o_lane_b_output_en)
		else $error("lane b not disabled");
	// load start and status
	start_pulse_a: assert property (
		o_load_start |-> o_cfg_source == `RPSC_SRC_EEPROM ##1 !o_load_start)
		else $error("bad load start pulse");
	start_cause_a: assert property (o_load_start |-> !$past(i_eeprom_load_req_n))
		else $error("load start without request");
	clean_done_a: assert property (
		$fell(o_eeprom_load_status_n) |-> $past(i_load_done) && !$past(i_load_error))
		else $error("status low without clean load");
	// loss pin and low power
	loss_od_a: assert property (!o_signal_loss_flag)
		else $error("loss pin driven high");
	sleep_mode_a: assert property (o_low_power |-> o_op_mode == `RPSC_MODE_ESATA)
		else $error("low power outside esata");
	wake_up_a: assert property ((i_signal_detect != 2'h0) [*5] |-> !o_low_power)
		else $error("low power with signal");
	cover property (o_load_start);
	cover property ($fell(o_eeprom_load_status_n));
	cover property ($rose(o_low_power));
	cover property (o_irq);
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the repeater strap and control block
`default_nettype none
`include "rpsc_regs.vh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = 1'h0, i_sys_rst = 1'h1, i_eeprom_load_req_n = 1'h1, i_output_disable = 1'h0;
	logic i_wr = 1'h0, i_rd = 1'h0, fail = 1'h0, i_load_done, i_load_error;
	logic [1:0] i_mgmt_bus_enable = 2'h0, i_swing_select = 2'h0, i_mode_strap = 2'h0;
	logic [1:0] i_detect_threshold_strap = 2'h0, i_signal_detect = 2'h3;
	logic [3:0] i_lane_a_eq_strap = 4'h0, i_lane_b_eq_strap = 4'h0, i_deemph_strap = 4'h0;
	logic [7:0] i_addr = 8'h00, lat = 8'h01, o_slave_addr;
	logic [31:0] i_wr_data = 32'h0, o_rd_data;
	logic [19:0] v = 20'h0;
	logic [15:0] seed = 16'h33EE;
	logic o_irq, o_load_start, o_eeprom_load_status_n, o_lane_a_output_en, o_lane_b_output_en;
	logic o_low_power, o_signal_loss_flag, o_signal_loss_flag_oe_n;
	logic [1:0] o_cfg_source, o_lane_a_swing, o_lane_b_swing, o_op_mode, o_detect_threshold;
	logic [3:0] o_lane_a_eq, o_lane_b_eq, o_lane_a_deemph, o_lane_b_deemph;
	int mismatches = 0, n_tests = 0, starts = 0, s0;

	rpsc_top i_rpsc_top (.*);
	rpsc_loader_model i_rpsc_loader_model (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
		.i_start(o_load_start), .i_fail(fail), .i_lat(lat), .o_done(i_load_done),
		.o_error(i_load_error));

	////////////////////////////////////////////////////////////////////////////////
	// clock and start pulse count
	always #25 i_clock = ~i_clock;
	always @(posedge i_clock) if (o_load_start) starts++;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [1:0] swing_of(input logic [1:0] c);
		return (c == `RPSC_LVL_LOW) ? `RPSC_SWING_700MV : (c == `RPSC_LVL_20K) ? `RPSC_SWING_1V2
			: (c == `RPSC_LVL_FLOAT) ? `RPSC_SWING_1V0 : `RPSC_SWING_MAX;
	endfunction
	function automatic logic [7:0] addr_of(input logic [19:0] c);
		return (c[15:14] == `RPSC_LVL_HIGH) ? `RPSC_ADDR_FIXED
			: (`RPSC_ADDR_BASE | {3'h0, &c[9:8], &c[7:6], &c[5:4], &c[3:2], 1'h0});
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wr_data <= d;
		i_wr <= 1'h1;
		@(posedge i_clock);
		i_wr <= 1'h0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'h1;
		@(posedge i_clock);
		i_rd <= 1'h0;
		#1;
		chk(o_rd_data, e);
	endtask
	// new straps under reset, then wait for their capture
	task automatic boot(input logic [19:0] c);
		@(posedge i_clock);
		{i_detect_threshold_strap, i_mode_strap, i_swing_select, i_deemph_strap,
			i_lane_b_eq_strap, i_lane_a_eq_strap, i_mgmt_bus_enable} <= c;
		i_sys_rst <= 1'h1;
		repeat (10) @(posedge i_clock);
		i_sys_rst <= 1'h0;
		tick(25);
	endtask
	// one load with a second request while busy when slow
	task automatic load(input logic f, input logic [7:0] l, input logic [31:0] ev);
		int n0;
		n0 = starts;
		@(posedge i_clock);
		fail <= f;
		lat <= l;
		i_eeprom_load_req_n <= 1'h0;
		tick(5);
		chk(o_eeprom_load_status_n, 1'h1);
		@(posedge i_clock);
		i_eeprom_load_req_n <= 1'h1;
		if (l > 8'h14) begin
			tick(3);
			@(posedge i_clock);
			i_eeprom_load_req_n <= 1'h0;
			tick(4);
			@(posedge i_clock);
			i_eeprom_load_req_n <= 1'h1;
		end
		tick(l + 8);
		chk(starts - n0, 1);
		chk(o_eeprom_load_status_n, f);
		chk(o_irq, 1'h1);
		rd_reg(`RPSC_OFS_STATUS, ev);
		tick(2);
		chk(o_irq, 1'h0);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			v = {2'(i + 1), 2'(i + 3), 2'(i / 2), seed[3:0], {2{seed[7]}}, {2{seed[6]}},
				{2{seed[5]}}, {2{seed[4]}}, 2'(i)};
			boot(v);
			chk(o_cfg_source, (v[1:0] == 2'h3) ? 2'h2 : (v[1:0] == 2'h2) ? 2'h1 : 2'h0);
			chk(o_op_mode, v[17:16]);
			chk(o_detect_threshold, v[19:18]);
			chk(o_lane_b_swing, swing_of(v[15:14]));
			chk(o_lane_a_swing, (v[1:0] < 2'h2) ? 2'h0 : swing_of(v[15:14]));
			if (v[1:0] == `RPSC_LVL_HIGH)
				chk(o_slave_addr, addr_of(v));
			if (v[1:0] < 2'h2)
				chk({o_lane_a_eq, o_lane_b_eq, o_lane_a_deemph, o_lane_b_deemph},
					{v[5:2], v[9:6], v[13:10], v[13:10]});
			else
				chk({o_lane_a_eq, o_lane_b_eq}, 8'h00);
		end
		@(posedge i_clock);
		i_detect_threshold_strap <= ~v[19:18];
		tick(4);
		chk(o_detect_threshold, v[19:18]);
		rd_reg(`RPSC_OFS_MASK, 32'h0);
		wr_reg(`RPSC_OFS_STRAP, 32'h0);
		rd_reg(`RPSC_OFS_STRAP, {11'h0, 1'h1, v});
		rd_reg(8'h1C, 32'h0);
		wr_reg(`RPSC_OFS_LANE_A, 32'h3A5);
		wr_reg(`RPSC_OFS_CTRL, 32'h4);
		rd_reg(`RPSC_OFS_CTRL, 32'h4);
		tick(3);
		chk({o_lane_a_eq, o_lane_a_deemph, o_lane_a_swing}, 10'h16B);
		@(posedge i_clock);
		i_signal_detect <= 2'h2;
		for (int s = 0; s < 3; s++) begin
			wr_reg(`RPSC_OFS_CTRL, 32'(s));
			tick(5);
			chk(o_signal_loss_flag_oe_n, s != 1);
		end
		chk(o_signal_loss_flag, 1'h0);
		rd_reg(`RPSC_OFS_STATUS, 32'h4);
		rd_reg(`RPSC_OFS_STATE, {16'h0, addr_of(v), v[17:16], 4'h8, `RPSC_SRC_SLAVE});
		for (int x = 1; x >= 0; x--) begin
			@(posedge i_clock);
			i_output_disable <= x[0];
			tick(5);
			chk({o_lane_a_output_en, o_lane_b_output_en}, {1'h1, !x[0]});
		end
		@(posedge i_clock);
		i_signal_detect <= 2'h3;
		boot(20'h00002);
		wr_reg(`RPSC_OFS_MASK, 32'hF);
		rd_reg(`RPSC_OFS_STATUS, 32'h0);
		load(1'h0, 8'h02, 32'h1);
		load(1'h1, 8'h28, 32'h2);
		load(1'h0, 8'h3C, 32'h1);
		@(posedge i_clock);
		i_signal_detect <= 2'h0;
		boot(20'h10000);
		s0 = starts;
		@(posedge i_clock);
		i_eeprom_load_req_n <= 1'h0;
		tick(8);
		chk(starts - s0, 0);
		@(posedge i_clock);
		i_eeprom_load_req_n <= 1'h1;
		tick(1860);
		chk(o_low_power, 1'h0);
		tick(150);
		chk(o_low_power, 1'h1);
		@(posedge i_clock);
		i_signal_detect <= 2'h1;
		tick(5);
		chk(o_low_power, 1'h0);
		give_verdict();
	end

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge i_clock);
		mismatches++;
		give_verdict();
	end
endmodule

bind rpsc_top rpsc_monitor i_rpsc_monitor (.*);
`default_nettype wire
